/* File: logic/ssrd_pkg.sv */
/*
  Shared types and constants for the setpoint select, ramp and dwell block.
  Assumes a 32-bit APB register bus and 16-bit signed process values.
*/
`default_nettype none

package ssrd_pkg;

  // ----------------------------------------------------------------
  // Widths and bus
  // ----------------------------------------------------------------
  localparam int DW = 16;
  localparam int GW = 10;
  localparam int PW = 7;
  localparam int AW = 8;

  localparam logic [AW-1:0] OFS_CFG    = 8'h00;
  localparam logic [AW-1:0] OFS_SETPT  = 8'h04;
  localparam logic [AW-1:0] OFS_RAMP   = 8'h08;
  localparam logic [AW-1:0] OFS_GAIN1  = 8'h0C;
  localparam logic [AW-1:0] OFS_GAIN2  = 8'h10;
  localparam logic [AW-1:0] OFS_CAP    = 8'h14;
  localparam logic [AW-1:0] OFS_STATUS = 8'h18;

  localparam logic [31:0] CFG_WMASK  = 32'h00FF_0FFF;
  localparam logic [31:0] GAIN_WMASK = 32'h3FFF_FFFF;
  localparam logic [31:0] CAP_WMASK  = 32'h0000_7F7F;
  localparam logic [PW-1:0] CAP_FULL = 7'h64;
  localparam logic [PW-1:0] PWR_ZERO = 7'h00;

  // ----------------------------------------------------------------
  // Modes and error codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    EVENT_NONE, SECONDARY_SETPOINT, ALTERNATE_GAINS_SELECT,
    SETPOINT_AND_GAINS_SWITCH, RESET_ALARM_ONE, RESET_ALARM_TWO,
    RESET_ALARM_BOTH
  } ssrd_evfn_t;

  typedef enum logic [2:0] {
    SINGLE_SETPOINT, FIXED_DUAL_SETPOINT, RAMP_PER_MINUTE,
    RAMP_PER_HOUR, REMOTE_INPUT_ONE, REMOTE_INPUT_TWO
  } ssrd_spmode_t;

  typedef enum logic [1:0] {
    PV_INPUT_ONE, PV_INPUT_TWO, DIFF_ONE_MINUS_TWO, DIFF_TWO_MINUS_ONE
  } ssrd_pvmode_t;

  typedef enum logic [3:0] {
    ERR_NONE, ERR_DUAL_DWELL, ERR_SAME_INPUT_ONE, ERR_SAME_INPUT_TWO,
    ERR_DIFF_REMOTE, ERR_DIFF_UNITS
  } ssrd_err_t;

  // ----------------------------------------------------------------
  // Register layouts and internal state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]   rsvd_hi;
    logic [1:0]   input_two_decimal;
    logic [1:0]   input_two_unit;
    logic [1:0]   input_one_decimal;
    logic [1:0]   input_one_unit;
    logic [3:0]   rsvd_mid;
    logic         alarm_two_function;
    logic         alarm_one_function;
    logic         second_setpoint_format;
    ssrd_pvmode_t process_value_source_mode;
    ssrd_spmode_t setpoint_source_mode;
    ssrd_evfn_t   event_function_select;
  } ssrd_cfg_t;

  typedef struct packed {
    logic signed [DW-1:0] secondary_setpoint;
    logic signed [DW-1:0] primary_setpoint;
  } ssrd_sp_t;

  typedef struct packed {
    logic [DW-1:0] dwell_time;
    logic [DW-1:0] ramp_rate;
  } ssrd_ramp_t;

  typedef struct packed {
    logic [1:0]    rsvd;
    logic [GW-1:0] deriv;
    logic [GW-1:0] integ;
    logic [GW-1:0] prop;
  } ssrd_gain_t;

  typedef struct packed {
    logic [16:0]   rsvd_hi;
    logic [PW-1:0] out_two_power_cap;
    logic          rsvd_lo;
    logic [PW-1:0] out_one_power_cap;
  } ssrd_cap_t;

  typedef struct packed {
    logic [7:0]           rsvd;
    logic                 gain_second;
    logic                 fallback;
    logic                 alarm_two;
    logic                 alarm_one;
    ssrd_err_t            err;
    logic signed [DW-1:0] working;
  } ssrd_stat_t;

  localparam ssrd_cap_t CAP_RESET = '{rsvd_hi: '0, out_two_power_cap: CAP_FULL,
                                      rsvd_lo: 1'b0, out_one_power_cap: CAP_FULL};

  typedef struct packed {
    logic                 ev_s1;
    logic                 ev_s2;
    ssrd_cfg_t            cfg;
    ssrd_sp_t             spt;
    ssrd_ramp_t           rmp;
    ssrd_gain_t           g1;
    ssrd_gain_t           g2;
    ssrd_cap_t            cap;
    logic [31:0]          rdata;
    logic                 started;
    logic signed [DW-1:0] wsp;
    logic signed [DW-1:0] pv;
    logic signed [DW-1:0] prev_tgt;
    logic [DW-1:0]        prev_rate;
    logic [31:0]          acc;
    logic                 below;
    logic                 pv_valid;
    logic                 run;
    logic [31:0]          pre;
    logic [DW-1:0]        cnt;
    logic                 alarm1;
    logic                 alarm2;
    logic                 fallback;
    logic                 gsec;
    ssrd_err_t            err;
    ssrd_gain_t           act;
    logic [PW-1:0]        drv1;
    logic [PW-1:0]        drv2;
  } ssrd_state_t;

endpackage

`default_nettype wire

/* File: logic/ssrd_top.sv */
/*
  Setpoint and gain selection, setpoint ramp, dwell timer, input routing,
  configuration checks and output power caps, with an APB register slave.
  Assumes converted inputs, sample tick, tuning results and demands come
  from logic on clk; only the event pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module ssrd_top
  import ssrd_pkg::*;
#(
  parameter int unsigned TICKS_PER_MINUTE = 60,
  parameter int unsigned TICKS_PER_HOUR   = 3600,
  parameter int unsigned DWELL_TICKS      = 60
)(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // APB slave
  input  wire logic [AW-1:0]        paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  // Process inputs
  input  wire logic                 sample_tick,
  input  wire logic signed [DW-1:0] input_one_value,
  input  wire logic signed [DW-1:0] input_two_value,
  input  wire logic                 remote_signal_lost,
  input  wire logic                 event_in,
  // Tuning results
  input  wire logic                 tune_done,
  input  wire logic [GW-1:0]        tune_prop,
  input  wire logic [GW-1:0]        tune_integ,
  input  wire logic [GW-1:0]        tune_deriv,
  // Output demands
  input  wire logic [PW-1:0]        auto_demand_one,
  input  wire logic [PW-1:0]        auto_demand_two,
  input  wire logic                 manual_active,
  input  wire logic [PW-1:0]        manual_one,
  input  wire logic [PW-1:0]        manual_two,
  // Results
  output var  logic signed [DW-1:0] working_setpoint,
  output var  logic signed [DW-1:0] process_value,
  output var  logic [GW-1:0]        active_prop,
  output var  logic [GW-1:0]        active_integ,
  output var  logic [GW-1:0]        active_deriv,
  output var  logic [3:0]           error_code,
  output var  logic                 alarm_one,
  output var  logic                 alarm_two,
  output var  logic                 manual_fallback,
  output var  logic [PW-1:0]        drive_one,
  output var  logic [PW-1:0]        drive_two
);

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  ssrd_state_t          s;
  ssrd_state_t          n;
  logic                 ev_act;
  ssrd_evfn_t           efn;
  ssrd_spmode_t         spm;
  ssrd_pvmode_t         pvm;
  logic                 dual_ok;
  logic                 sec_sp;
  logic signed [DW-1:0] sp2_eff;
  logic                 remote1;
  logic                 remote2;
  logic signed [DW-1:0] tgt;
  logic signed [DW-1:0] pv_now;
  logic                 ramping;
  logic [31:0]          ramp_div;
  logic [31:0]          rate32;
  logic                 gsec;
  logic                 clr1;
  logic                 clr2;
  logic                 dwell_en;
  logic                 reach;
  logic                 apb_wr;
  logic                 mapped;
  ssrd_err_t            err_now;
  logic [PW-1:0]        cap1_w;
  logic [PW-1:0]        cap2_w;

  // Only the second stage of the event synchroniser is looked at.
  assign ev_act   = s.ev_s2;
  assign efn      = s.cfg.event_function_select;
  assign spm      = s.cfg.setpoint_source_mode;
  assign pvm      = s.cfg.process_value_source_mode;
  assign dual_ok  = (spm == FIXED_DUAL_SETPOINT) || (spm == RAMP_PER_MINUTE)
                    || (spm == RAMP_PER_HOUR);
  assign sec_sp   = ev_act && dual_ok && ((efn == SECONDARY_SETPOINT)
                    || (efn == SETPOINT_AND_GAINS_SWITCH));
  assign sp2_eff  = s.cfg.second_setpoint_format
                    ? s.spt.primary_setpoint + s.spt.secondary_setpoint
                    : s.spt.secondary_setpoint;
  assign remote1  = (spm == REMOTE_INPUT_ONE);
  assign remote2  = (spm == REMOTE_INPUT_TWO);
  assign tgt      = remote1 ? input_one_value
                  : remote2 ? input_two_value
                  : sec_sp  ? sp2_eff
                  : s.spt.primary_setpoint;
  assign ramping  = ((spm == RAMP_PER_MINUTE) || (spm == RAMP_PER_HOUR))
                    && (s.rmp.ramp_rate != '0);
  assign ramp_div = (spm == RAMP_PER_HOUR) ? 32'(TICKS_PER_HOUR)
                                           : 32'(TICKS_PER_MINUTE);
  assign rate32   = 32'(s.rmp.ramp_rate);
  assign gsec     = ev_act && ((efn == ALTERNATE_GAINS_SELECT)
                    || (efn == SETPOINT_AND_GAINS_SWITCH));
  assign clr1     = ev_act && ((efn == RESET_ALARM_ONE) || (efn == RESET_ALARM_BOTH));
  assign clr2     = ev_act && ((efn == RESET_ALARM_TWO) || (efn == RESET_ALARM_BOTH));
  assign dwell_en = s.cfg.alarm_one_function ^ s.cfg.alarm_two_function;
  assign cap1_w   = s.cap.out_one_power_cap;
  assign cap2_w   = s.cap.out_two_power_cap;

  always_comb
  begin
    unique case (pvm)
      PV_INPUT_ONE:       pv_now = input_one_value;
      PV_INPUT_TWO:       pv_now = input_two_value;
      DIFF_ONE_MINUS_TWO: pv_now = input_one_value - input_two_value;
      DIFF_TWO_MINUS_ONE: pv_now = input_two_value - input_one_value;
    endcase
  end

  // Crossing in either direction counts, so a sample that jumps past
  // the working setpoint between ticks still arms the timer.
  assign reach = s.pv_valid && ((pv_now == s.wsp)
                 || ((pv_now < s.wsp) != s.below));

  // ----------------------------------------------------------------
  // Configuration checks, in priority order
  // ----------------------------------------------------------------
  always_comb
  begin
    err_now = ERR_NONE;
    if (s.cfg.alarm_one_function && s.cfg.alarm_two_function)
      err_now = ERR_DUAL_DWELL;
    else if (remote1 && (pvm == PV_INPUT_ONE))
      err_now = ERR_SAME_INPUT_ONE;
    else if (remote2 && (pvm == PV_INPUT_TWO))
      err_now = ERR_SAME_INPUT_TWO;
    else if ((remote1 || remote2) && pvm[1])
      err_now = ERR_DIFF_REMOTE;
    else if (pvm[1] && ((s.cfg.input_one_unit != s.cfg.input_two_unit)
             || (s.cfg.input_one_decimal != s.cfg.input_two_decimal)))
      err_now = ERR_DIFF_UNITS;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apb_wr  = psel && penable && pwrite;
  assign mapped  = (paddr == OFS_CFG) || (paddr == OFS_SETPT) || (paddr == OFS_RAMP)
                   || (paddr == OFS_GAIN1) || (paddr == OFS_GAIN2)
                   || (paddr == OFS_CAP) || (paddr == OFS_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       fire;
    logic       chan_clr;
    logic       chan_alarm;
    ssrd_stat_t st;
    fire       = 1'b0;
    chan_clr   = s.cfg.alarm_one_function ? clr1 : clr2;
    chan_alarm = s.cfg.alarm_one_function ? s.alarm1 : s.alarm2;
    st         = '{rsvd: '0, gain_second: s.gsec, fallback: s.fallback,
                   alarm_two: s.alarm2, alarm_one: s.alarm1, err: s.err,
                   working: s.wsp};
    n       = s;
    n.ev_s1 = event_in;
    n.ev_s2 = s.ev_s1;

    // Register writes take effect at the access edge.
    if (apb_wr)
    begin
      unique case (paddr)
        OFS_CFG:   n.cfg = ssrd_cfg_t'(pwdata & CFG_WMASK);
        OFS_SETPT: n.spt = ssrd_sp_t'(pwdata);
        OFS_RAMP:  n.rmp = ssrd_ramp_t'(pwdata);
        OFS_GAIN1: n.g1  = ssrd_gain_t'(pwdata & GAIN_WMASK);
        OFS_GAIN2: n.g2  = ssrd_gain_t'(pwdata & GAIN_WMASK);
        OFS_CAP:   n.cap = ssrd_cap_t'(pwdata & CAP_WMASK);
        default:   ;
      endcase
      if (n.cap.out_one_power_cap > CAP_FULL)
        n.cap.out_one_power_cap = CAP_FULL;
      if (n.cap.out_two_power_cap > CAP_FULL)
        n.cap.out_two_power_cap = CAP_FULL;
    end

    // Tuning results win over a software write in the same cycle.
    if (tune_done)
    begin
      if (gsec)
        n.g2 = '{rsvd: '0, deriv: tune_deriv, integ: tune_integ, prop: tune_prop};
      else
        n.g1 = '{rsvd: '0, deriv: tune_deriv, integ: tune_integ, prop: tune_prop};
    end

    // Read data is captured in the setup cycle, so no wait state is needed.
    if (psel && !penable)
    begin
      unique case (paddr)
        OFS_CFG:    n.rdata = s.cfg;
        OFS_SETPT:  n.rdata = s.spt;
        OFS_RAMP:   n.rdata = s.rmp;
        OFS_GAIN1:  n.rdata = s.g1;
        OFS_GAIN2:  n.rdata = s.g2;
        OFS_CAP:    n.rdata = s.cap;
        OFS_STATUS: n.rdata = st;
        default:    n.rdata = '0;
      endcase
    end

    // Setpoint ramp; one LSB per tick at most, so rates above the tick
    // rate are limited to the tick rate.
    if (!s.started || (tgt != s.prev_tgt) || (s.rmp.ramp_rate != s.prev_rate))
    begin
      n.started   = 1'b1;
      n.wsp       = pv_now;
      n.prev_tgt  = tgt;
      n.prev_rate = s.rmp.ramp_rate;
      n.acc       = '0;
    end
    else if (sample_tick && (s.wsp != tgt))
    begin
      if (s.acc + rate32 >= ramp_div)
      begin
        n.acc = s.acc + rate32 - ramp_div;
        n.wsp = (s.wsp < tgt) ? s.wsp + 16'sh0001 : s.wsp - 16'sh0001;
      end
      else
        n.acc = s.acc + rate32;
    end
    if (!ramping)
    begin
      n.wsp = tgt;
      n.acc = '0;
    end

    // Reach detection history.
    if (sample_tick)
    begin
      n.pv_valid = 1'b1;
      n.below    = (pv_now < s.wsp);
    end

    // Dwell timer on whichever channel holds the dwell function.
    if (!dwell_en || chan_clr)
    begin
      n.run = 1'b0;
      n.pre = '0;
      n.cnt = '0;
    end
    else if (!s.run)
    begin
      if (sample_tick && reach && !chan_alarm)
      begin
        n.run = 1'b1;
        n.pre = '0;
        n.cnt = '0;
      end
    end
    else if (s.cnt >= s.rmp.dwell_time)
    begin
      // Live comparison against the register, so an edit only moves expiry.
      fire  = 1'b1;
      n.run = 1'b0;
    end
    else if (sample_tick)
    begin
      if (s.pre == 32'(DWELL_TICKS - 1))
      begin
        n.pre = '0;
        n.cnt = s.cnt + 16'h0001;
      end
      else
        n.pre = s.pre + 32'h0000_0001;
    end

    if (clr1)
      n.alarm1 = 1'b0;
    if (clr2)
      n.alarm2 = 1'b0;
    if (fire && s.cfg.alarm_one_function)
      n.alarm1 = 1'b1;
    if (fire && s.cfg.alarm_two_function)
      n.alarm2 = 1'b1;

    n.err      = err_now;
    n.pv       = pv_now;
    n.gsec     = gsec;
    n.act      = gsec ? s.g2 : s.g1;
    n.fallback = (remote1 || remote2) && remote_signal_lost;

    if (n.fallback)
    begin
      n.drv1 = PWR_ZERO;
      n.drv2 = PWR_ZERO;
    end
    else if (manual_active)
    begin
      n.drv1 = manual_one;
      n.drv2 = manual_two;
    end
    else
    begin
      n.drv1 = (auto_demand_one > cap1_w) ? cap1_w : auto_demand_one;
      n.drv2 = (auto_demand_two > cap2_w) ? cap2_w : auto_demand_two;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s     <= '0;
      s.cap <= CAP_RESET;
    end
    else
      s <= n;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata           = s.rdata;
  assign working_setpoint = s.wsp;
  assign process_value    = s.pv;
  assign active_prop      = s.act.prop;
  assign active_integ     = s.act.integ;
  assign active_deriv     = s.act.deriv;
  assign error_code       = s.err;
  assign alarm_one        = s.alarm1;
  assign alarm_two        = s.alarm2;
  assign manual_fallback  = s.fallback;
  assign drive_one        = s.drv1;
  assign drive_two        = s.drv2;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fallback_zero: assert property (@(posedge clk) disable iff (rst)
    manual_fallback |-> (drive_one == PWR_ZERO) && (drive_two == PWR_ZERO))
    else $error("output not zero on remote loss");

  a_cap_one_limit: assert property (@(posedge clk) disable iff (rst)
    (!manual_fallback && !$past(manual_active)) |-> (drive_one <= $past(cap1_w)))
    else $error("output one exceeds its cap");

  a_manual_unclamped: assert property (@(posedge clk) disable iff (rst)
    (!manual_fallback && $past(manual_active)) |-> (drive_two == $past(manual_two)))
    else $error("manual value altered");

  a_dual_dwell_err: assert property (@(posedge clk) disable iff (rst)
    (s.cfg.alarm_one_function && s.cfg.alarm_two_function)
    |=> (error_code == ERR_DUAL_DWELL) && !s.run)
    else $error("dual dwell not rejected");

  a_same_input_err: assert property (@(posedge clk) disable iff (rst)
    (remote2 && (pvm == PV_INPUT_TWO) && !dwell_en && !s.cfg.alarm_one_function)
    |=> (error_code == ERR_SAME_INPUT_TWO))
    else $error("same input two not flagged");

  a_alarm_latched: assert property (@(posedge clk) disable iff (rst)
    (alarm_one && !clr1) |=> alarm_one)
    else $error("dwell alarm dropped");

  a_ramp_off_follow: assert property (@(posedge clk) disable iff (rst)
    !ramping |=> (working_setpoint == $past(tgt)))
    else $error("working setpoint not following target");

  a_ramp_step_bound: assert property (@(posedge clk) disable iff (rst)
    (ramping && s.started && (tgt == s.prev_tgt) && (s.rmp.ramp_rate == s.prev_rate))
    ##1 (ramping && $stable(tgt) && $stable(s.rmp.ramp_rate))
    |-> ((working_setpoint - $past(working_setpoint)) inside {-16'sd1, 16'sd0, 16'sd1}))
    else $error("ramp moved more than one step");

  a_gain_second: assert property (@(posedge clk) disable iff (rst)
    gsec |=> (active_prop == $past(s.g2.prop)) && (active_deriv == $past(s.g2.deriv)))
    else $error("second gain set not applied");

  a_tune_first: assert property (@(posedge clk) disable iff (rst)
    (tune_done && !gsec) |=> (s.g1.prop == $past(tune_prop)) ##1 (active_prop == s.g1.prop
    || $past(gsec)))
    else $error("tuning not stored in first set");

  a_diff_value: assert property (@(posedge clk) disable iff (rst)
    (pvm == DIFF_ONE_MINUS_TWO)
    |=> (process_value == ($past(input_one_value) - $past(input_two_value))))
    else $error("differential value wrong");

endmodule

`default_nettype wire

/* File: tb/ssrd_event_src.sv */
/*
  Model of the external contact that drives the event pin.
  Assumes the bench commands the contact on the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ssrd_event_src (
  // Clock and command
  input  wire logic clk,
  input  wire logic close_cmd,
  // Contact
  output var  logic contact
);
  // The contact moves one cycle late, like a relay closing after its coil.
  initial contact = 1'b0;
  always @(posedge clk) contact <= close_cmd;
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the setpoint select, ramp and dwell block.
  Assumes zero-wait APB and the small tick parameters set below.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_compared++; if ((a)!==(b)) begin num_errors++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top;
  import ssrd_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, tk = 0, lost = 0, ev = 0;
  logic td = 0, man = 0, perr, pready, pslverr, evp, a1, a2, fb;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic signed [DW-1:0] in1 = 16'h0011, in2 = 16'h0022, wsp, pv;
  logic [GW-1:0] tp = '0, ti = '0, tq = '0, ap, ai, adr;
  logic [PW-1:0] d1, d2, ad1 = 7'h40, ad2 = 7'h40, mv1 = 7'h00, mv2 = 7'h00;
  logic [3:0] err;
  int num_errors = 0, n_compared = 0, cyc = 0;
  ssrd_event_src src (.clk(clk), .close_cmd(ev), .contact(evp));
  ssrd_top #(.TICKS_PER_MINUTE(2), .TICKS_PER_HOUR(4), .DWELL_TICKS(2)) dut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(tk), .input_one_value(in1), .input_two_value(in2),
    .remote_signal_lost(lost), .event_in(evp), .tune_done(td), .tune_prop(tp),
    .tune_integ(ti), .tune_deriv(tq), .auto_demand_one(ad1), .auto_demand_two(ad2),
    .manual_active(man), .manual_one(mv1), .manual_two(mv2),
    .working_setpoint(wsp), .process_value(pv), .active_prop(ap), .active_integ(ai),
    .active_deriv(adr), .error_code(err), .alarm_one(a1), .alarm_two(a2),
    .manual_fallback(fb), .drive_one(d1), .drive_two(d2));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; perr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk) tk <= 1;
      @(posedge clk) tk <= 0;
    end
    wt(3);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(0, OFS_CAP, 0);
    `CHK(rd, 32'h00006464)
    apb(0, 8'h1C, 0);
    `CHK({perr, rd}, {1'b1, 32'h0})
    $display("test regs done");
  endtask
  task automatic t_setpt();
    apb(1, OFS_SETPT, 32'h00C80064);
    apb(1, OFS_CFG, 32'h00000011); wt(3);
    `CHK(wsp, 16'h0064)
    ev <= 1; wt(8);
    `CHK(wsp, 16'h00C8)
    apb(1, OFS_CFG, 32'h00000211); wt(3);
    `CHK(wsp, 16'h012C)
    apb(1, OFS_CFG, 32'h00000201); wt(3);
    `CHK(wsp, 16'h0064)
    ev <= 0; wt(8);
    $display("test setpoint done");
  endtask
  task automatic t_gains();
    apb(1, OFS_GAIN1, 32'h00300801);
    apb(1, OFS_GAIN2, 32'h00601404);
    apb(1, OFS_CFG, 32'h00000012); ev <= 1; wt(8);
    `CHK({ap, ai, adr}, {10'h4, 10'h5, 10'h6})
    @(posedge clk) begin td <= 1; tp <= 10'h7; ti <= 10'h8; tq <= 10'h9; end
    @(posedge clk) td <= 0; wt(3);
    `CHK({ap, ai, adr}, {10'h7, 10'h8, 10'h9})
    apb(1, OFS_CFG, 32'h00000013); wt(3);
    `CHK({wsp, ap}, {16'h00C8, 10'h7})
    ev <= 0; wt(8);
    `CHK({wsp, ap}, {16'h0064, 10'h1})
    @(posedge clk) begin td <= 1; tp <= 10'hA; ti <= 10'hB; tq <= 10'hC; end
    @(posedge clk) td <= 0; wt(3);
    `CHK({ap, ai, adr}, {10'hA, 10'hB, 10'hC})
    $display("test gains done");
  endtask
  task automatic t_ramp();
    apb(1, OFS_RAMP, 32'h00000001);
    apb(1, OFS_CFG, 32'h00000020);
    apb(1, OFS_SETPT, 32'h00000015); wt(3);
    `CHK(wsp, 16'h0011)
    tick(4);
    `CHK(wsp, 16'h0013)
    tick(6);
    `CHK(wsp, 16'h0015)
    apb(1, OFS_RAMP, 32'h00000000);
    apb(1, OFS_SETPT, 32'h00000030); wt(3);
    `CHK(wsp, 16'h0030)
    apb(1, OFS_RAMP, 32'h00000001);
    apb(1, OFS_CFG, 32'h00000030); tick(4);
    `CHK(wsp, 16'h0012)
    $display("test ramp done");
  endtask
  task automatic t_dwell();
    apb(1, OFS_SETPT, 32'h00000011);
    apb(1, OFS_RAMP, 32'h00020000);
    apb(1, OFS_CFG, 32'h00000400); tick(2);
    `CHK(a1, 1'b0)
    apb(1, OFS_RAMP, 32'h00030000); tick(8);
    `CHK({a1, a2}, 2'b10)
    in1 <= 16'h0050; tick(2);
    `CHK(a1, 1'b1)
    apb(0, OFS_STATUS, 32'h0);
    `CHK(rd, 32'h00100011)
    apb(1, OFS_CFG, 32'h00000404); ev <= 1; wt(8);
    `CHK(a1, 1'b0)
    ev <= 0; in1 <= 16'h0011; wt(8);
    apb(1, OFS_CFG, 32'h00000806); tick(8);
    `CHK({a1, a2}, 2'b01)
    ev <= 1; wt(8);
    `CHK(a2, 1'b0)
    ev <= 0; wt(8);
    $display("test dwell done");
  endtask
  task automatic t_errs();
    logic [31:0] c [6] = '{32'h40, 32'hD0, 32'h140, 32'hC10, 32'h10110, 32'h0};
    logic [3:0] e [6] = '{4'h2, 4'h3, 4'h4, 4'h1, 4'h5, 4'h0};
    for (int i = 0; i < 6; i++)
    begin
      apb(1, OFS_CFG, c[i]); wt(3);
      `CHK(err, e[i])
    end
    apb(1, OFS_CFG, 32'h110); wt(3);
    `CHK(pv, 16'hFFEF)
    apb(1, OFS_CFG, 32'h190); wt(3);
    `CHK(pv, 16'h0011)
    apb(1, OFS_CFG, 32'hC0); wt(3);
    `CHK({wsp, pv, err}, {16'h0011, 16'h0022, 4'h0})
    apb(1, OFS_CFG, 32'h50); lost <= 1; wt(3);
    `CHK({pv, wsp, fb, d1}, {16'h0011, 16'h0022, 1'b1, 7'h00})
    lost <= 0;
    $display("test errors done");
  endtask
  task automatic t_caps();
    apb(1, OFS_CFG, 32'h0);
    ad1 <= 7'h5A; ad2 <= 7'h5A;
    apb(1, OFS_CAP, 32'h00005032); wt(3);
    `CHK({d1, d2}, {7'h32, 7'h50})
    ad1 <= 7'h20; wt(3);
    `CHK(d1, 7'h20)
    man <= 1; mv1 <= 7'h5F; mv2 <= 7'h63; wt(3);
    `CHK({d1, d2}, {7'h5F, 7'h63})
    apb(1, OFS_CAP, 32'h00007F7F);
    apb(0, OFS_CAP, 32'h0);
    `CHK(rd, 32'h00006464)
    $display("test caps done");
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    wt(2);
    rst <= 0;
    t_regs(); t_setpt(); t_gains(); t_ramp(); t_dwell(); t_errs(); t_caps();
    give_verdict();
  end
endmodule

`default_nettype wire
